// file: include/dcl_params.svh
/*
 * Offsets, field positions, reset values and timing figures of the
 * offset correction and link configuration register group.
 * Assumes it is included by bare name from design files and the testbench.
 */
`ifndef DCL_PARAMS_SVH
`define DCL_PARAMS_SVH

// ****************************************************************
// Register indices; the byte address is four times the index
// ****************************************************************
`define DCL_IDX_OFFSET_MODE 8'h3d
`define DCL_IDX_LANE_CFG 8'h47
`define DCL_IDX_LINK_CTRL 8'h60
`define DCL_ADDR_W 12

// ****************************************************************
// Reset values
// ****************************************************************
`define DCL_RST_OFFSET_MODE 8'h00
`define DCL_RST_LANE_CFG 8'h00
`define DCL_RST_LINK_CTRL 8'h7f
`define DCL_RST_SYNC_CNT 5'h1f // Frames-per-multiframe-less-one field of the link reset value

// ****************************************************************
// Field positions
// ****************************************************************
`define DCL_OC_ON_BIT 0
`define DCL_OC_TC_LSB 1
`define DCL_OC_TC_MSB 2
`define DCL_LD_DEEMPH_LSB 0
`define DCL_LD_DEEMPH_MSB 2
`define DCL_LD_SWING_LSB 4
`define DCL_LD_SWING_MSB 6
`define DCL_LC_ON_BIT 0
`define DCL_LC_FIXED_BIT 1
`define DCL_LC_K_LSB 2
`define DCL_LC_K_MSB 6
`define DCL_LC_SCR_BIT 7

// ****************************************************************
// Filter feedback shifts per time-constant code (about Fs*tc)
// 8.2 us, 65 us, 524 us, 4.2 ms at 500 MSPS -> 2^12, 2^15, 2^18, 2^21
// ****************************************************************
`define DCL_SHIFT_TC0 5'h0c
`define DCL_SHIFT_TC1 5'h0f
`define DCL_SHIFT_TC2 5'h12
`define DCL_SHIFT_TC3 5'h15

// ****************************************************************
// Idle pattern emitted while the link is off
// ****************************************************************
`define DCL_IDLE_PATTERN 8'h55

`endif

// file: include/dcl_pkg.sv
/*
 * Types shared by the register group and the offset filter.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dcl_pkg;
    // Output lane word source
    typedef enum logic [1:0] {
        DCL_LANE_IDLE = 2'b01,
        DCL_LANE_DATA = 2'b10
    } dcl_lane_e;
    typedef logic [7:0] dcl_reg_t;
endpackage

// file: hw/dcl_offset_filter.sv
/*
 * First-order recursive DC offset estimator and subtractor.
 * Assumes samples arrive one per pclk as signed words.
 */
`timescale 1ns/1ps
`include "dcl_params.svh"
module dcl_offset_filter
    import dcl_pkg::*;
#(
    parameter int DW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic [1:0] tc_sel,
    input wire logic signed [DW-1:0] din,
    output logic signed [DW-1:0] dout
);
    localparam int AW = DW + 24; // Accumulator holds mean scaled by 2^shift
    logic signed [AW-1:0] acc_q, acc_d; // Mean estimate, scaled
    logic signed [DW-1:0] dout_q, dout_d; // Registered output sample
    logic [4:0] shift; // Feedback shift from time constant

    // Shift decode per time-constant code
    always_comb begin
        case (tc_sel)
            2'h0: shift = `DCL_SHIFT_TC0;
            2'h1: shift = `DCL_SHIFT_TC1;
            2'h2: shift = `DCL_SHIFT_TC2;
            default: shift = `DCL_SHIFT_TC3;
        endcase
    end

    // Estimate update and subtraction
    always_comb begin
        logic signed [AW-1:0] mean;
        logic signed [DW+1:0] diff;
        mean = acc_q >>> shift;
        diff = (DW+2)'(din) - (DW+2)'(mean);
        acc_d = acc_q;
        dout_d = din;
        if (enable) begin
            acc_d = acc_q + AW'(diff);
            if (diff > (DW+2)'(2 ** (DW-1) - 1)) begin
                dout_d = DW'(2 ** (DW-1) - 1);
            end else if (diff < -(DW+2)'(2 ** (DW-1))) begin
                dout_d = DW'(-(2 ** (DW-1)));
            end else begin
                dout_d = DW'(diff);
            end
        end else begin
            acc_d = '0; // Bypass and forget estimate
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= '0;
            dout_q <= '0;
        end else begin
            acc_q <= acc_d;
            dout_q <= dout_d;
        end
    end

    assign dout = dout_q;

    // Bypass passes sample unchanged one cycle later
    a_bypass_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (!enable && $past(!enable)) |=> (dout == $past(din))) else $error("bypass");
    // Bypass forgets the estimate so a later enable starts afresh
    a_acc_clear: assert property (@(posedge pclk) disable iff (!presetn)
        !enable |=> (acc_q == '0)) else $error("acc clear");
endmodule // dcl_offset_filter

// file: hw/dcl_regs.sv
/*
 * APB register group: offset correction mode, lane driver config and
 * link control. Drives the offset filter and the serial lane word source.
 * Assumes APB3 master on pclk; sample stream and lane words on pclk.
 */
`timescale 1ns/1ps
`include "dcl_params.svh"
// Overview of operation
// - Correct offset only when enable bit set
// - Time-constant field selects filter feedback shift
// - Swing field selects eight rising amplitudes
// - De-emphasis field selects eight rising levels
// - Bit 7 enables the data scrambler
// - Field 6:2 holds frames per multiframe less one
// - Link on: carry data while the sync count runs down
// - Link off: lanes emit 01010101 pattern
module dcl_regs
    import dcl_pkg::*;
#(
    parameter int DW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`DCL_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [DW-1:0] sample_in,
    output logic signed [DW-1:0] sample_out,
    input wire logic [7:0] link_word_in,
    output logic [7:0] lane_word,
    output logic link_on,
    output logic scrambler_on,
    output logic [4:0] frames_per_multiframe_less_one,
    output logic [2:0] driver_swing_sel,
    output logic [2:0] driver_deemph_sel,
    output logic link_sync_active
);
    // ****************************************************************
    // Register storage
    // ****************************************************************
    dcl_reg_t offset_correction_mode_q, offset_correction_mode_d; // Offset mode
    dcl_reg_t lane_driver_config_q, lane_driver_config_d; // Lane driver
    dcl_reg_t link_control_one_q, link_control_one_d; // Link control
    logic [31:0] prdata_q, prdata_d; // Read data
    logic [4:0] sync_cnt_q, sync_cnt_d; // Frames left in synchronization
    logic [7:0] lane_q, lane_d; // Lane word register
    dcl_lane_e src; // Lane word source

    // Decode byte address to a register select
    function automatic logic [1:0] reg_sel(input logic [`DCL_ADDR_W-1:0] a);
        if (a == {2'h0, `DCL_IDX_OFFSET_MODE, 2'h0}) begin
            return 2'h1;
        end else if (a == {2'h0, `DCL_IDX_LANE_CFG, 2'h0}) begin
            return 2'h2;
        end else if (a == {2'h0, `DCL_IDX_LINK_CTRL, 2'h0}) begin
            return 2'h3;
        end
        return 2'h0;
    endfunction

    logic access; // APB access phase
    logic [1:0] sel; // Selected register
    assign access = psel && penable;
    assign sel = reg_sel(paddr);
    assign pready = 1'b1; // Zero wait states
    assign pslverr = access && (sel == 2'h0); // Unmapped address

    // ****************************************************************
    // Register writes and reads
    // ****************************************************************
    always_comb begin
        offset_correction_mode_d = offset_correction_mode_q;
        lane_driver_config_d = lane_driver_config_q;
        link_control_one_d = link_control_one_q;
        prdata_d = prdata_q;
        if (access && pwrite) begin
            case (sel)
                2'h1: offset_correction_mode_d = pwdata[7:0];
                2'h2: lane_driver_config_d = pwdata[7:0];
                2'h3: link_control_one_d = pwdata[7:0];
                default: ;
            endcase
        end
        if (psel && !penable && !pwrite) begin
            // Setup phase: fetch read data for access phase
            case (reg_sel(paddr))
                2'h1: prdata_d = {24'h0, offset_correction_mode_q};
                2'h2: prdata_d = {24'h0, lane_driver_config_q};
                2'h3: prdata_d = {24'h0, link_control_one_q};
                default: prdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_correction_mode_q <= `DCL_RST_OFFSET_MODE;
            lane_driver_config_q <= `DCL_RST_LANE_CFG;
            link_control_one_q <= `DCL_RST_LINK_CTRL;
            prdata_q <= 32'h0;
        end else begin
            offset_correction_mode_q <= offset_correction_mode_d;
            lane_driver_config_q <= lane_driver_config_d;
            link_control_one_q <= link_control_one_d;
            prdata_q <= prdata_d;
        end
    end
    assign prdata = prdata_q;

    // ****************************************************************
    // Field outputs
    // ****************************************************************
    assign driver_swing_sel = lane_driver_config_q[`DCL_LD_SWING_MSB:`DCL_LD_SWING_LSB];
    assign driver_deemph_sel =
        lane_driver_config_q[`DCL_LD_DEEMPH_MSB:`DCL_LD_DEEMPH_LSB];
    assign link_on = link_control_one_q[`DCL_LC_ON_BIT];
    assign scrambler_on = link_control_one_q[`DCL_LC_SCR_BIT];
    assign frames_per_multiframe_less_one =
        link_control_one_q[`DCL_LC_K_MSB:`DCL_LC_K_LSB];

    // ****************************************************************
    // Offset correction filter
    // ****************************************************************
    dcl_offset_filter #(.DW(DW)) u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .enable(offset_correction_mode_q[`DCL_OC_ON_BIT]),
        .tc_sel(offset_correction_mode_q[`DCL_OC_TC_MSB:`DCL_OC_TC_LSB]),
        .din(sample_in),
        .dout(sample_out)
    );

    // ****************************************************************
    // Lane word source: idle pattern when off, data when on; sync count runs alongside
    // ****************************************************************
    assign src = link_on ? DCL_LANE_DATA : DCL_LANE_IDLE;

    always_comb begin
        sync_cnt_d = sync_cnt_q;
        lane_d = `DCL_IDLE_PATTERN;
        case (src)
            DCL_LANE_IDLE: begin
                lane_d = `DCL_IDLE_PATTERN;
                sync_cnt_d = frames_per_multiframe_less_one; // Rearm sync
            end
            DCL_LANE_DATA: begin
                lane_d = link_word_in;
                if (sync_cnt_q != 5'h0) begin
                    sync_cnt_d = sync_cnt_q - 5'h1;
                end
            end
            default: lane_d = `DCL_IDLE_PATTERN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_cnt_q <= `DCL_RST_SYNC_CNT;
            lane_q <= 8'h0;
        end else begin
            sync_cnt_q <= sync_cnt_d;
            lane_q <= lane_d;
        end
    end
    assign lane_word = lane_q;
    assign link_sync_active = link_on && (sync_cnt_q != 5'h0);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // One APB write access to each mapped register
    sequence s_oc_write;
        access && pwrite && (sel == 2'h1);
    endsequence
    sequence s_ld_write;
        access && pwrite && (sel == 2'h2);
    endsequence
    sequence s_lc_write;
        access && pwrite && (sel == 2'h3);
    endsequence

    // Lane word source follows the link enable one cycle later
    a_idle_pattern: assert property (@(posedge pclk) disable iff (!presetn)
        !link_on |=> (lane_word == `DCL_IDLE_PATTERN)) else $error("idle pattern");
    a_data_pass: assert property (@(posedge pclk) disable iff (!presetn)
        link_on |=> (lane_word == $past(link_word_in))) else $error("data");

    // Link control fields take the written value
    a_scr_follow: assert property (@(posedge pclk) disable iff (!presetn)
        s_lc_write |=> (scrambler_on == $past(pwdata[`DCL_LC_SCR_BIT]))) else $error("scr");
    a_k_follow: assert property (@(posedge pclk) disable iff (!presetn)
        s_lc_write |=> (frames_per_multiframe_less_one
            == $past(pwdata[`DCL_LC_K_MSB:`DCL_LC_K_LSB]))) else $error("k");
    a_link_follow: assert property (@(posedge pclk) disable iff (!presetn)
        s_lc_write |=> (link_on == $past(pwdata[`DCL_LC_ON_BIT]))) else $error("link");

    // Lane driver fields take the written value; de-emphasis holds otherwise
    a_swing_follow: assert property (@(posedge pclk) disable iff (!presetn)
        s_ld_write |=> (driver_swing_sel
            == $past(pwdata[`DCL_LD_SWING_MSB:`DCL_LD_SWING_LSB]))) else $error("swing");
    a_deemph_follow: assert property (@(posedge pclk) disable iff (!presetn)
        s_ld_write |=> (driver_deemph_sel
            == $past(pwdata[`DCL_LD_DEEMPH_MSB:`DCL_LD_DEEMPH_LSB]))) else $error("deemph");
    a_deemph_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(access && pwrite && (sel == 2'h2)) |=> $stable(driver_deemph_sel))
        else $error("deemph hold");

    // Sync phase: loaded with the field on enable, one step a cycle, bounded
    a_sync_load: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(link_on) |-> (sync_cnt_q == $past(frames_per_multiframe_less_one)))
        else $error("sync load");
    a_sync_step: assert property (@(posedge pclk) disable iff (!presetn)
        link_sync_active |=> (sync_cnt_q == $past(sync_cnt_q) - 5'h1)) else $error("sync step");
    a_sync_ends: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(link_on) |-> ##[0:32] !link_sync_active) else $error("sync");

    // Offset mode fields take the written value
    a_oc_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_oc_write |=> (offset_correction_mode_q[`DCL_OC_TC_MSB:`DCL_OC_ON_BIT]
            == $past(pwdata[`DCL_OC_TC_MSB:`DCL_OC_ON_BIT]))) else $error("mode");
endmodule // dcl_regs

// file: dv/testbench.sv
/*
 * Self-checking bench for the offset correction and link config group.
 * Assumes dcl_pkg, dcl_params.svh and hw/dcl_regs.sv are compiled first.
 */
`timescale 1ns/1ps
`include "dcl_params.svh"
module testbench;
    import dcl_pkg::*;
    // ****************************************************************
    // Signals and constants
    // ****************************************************************
    logic pclk = 1'b0; // Bus clock, 20 MHz
    logic presetn = 1'b0; // Active low reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, link_on, scrambler_on, link_sync_active;
    logic signed [15:0] sample_in = 16'sh0000, sample_out, ref_out;
    logic [7:0] link_word_in = 8'h00, lane_word;
    logic [4:0] frames_per_multiframe_less_one;
    logic [2:0] driver_swing_sel, driver_deemph_sel;
    logic [31:0] rd;
    logic err;
    int n_fail = 0, checked = 0, n;
    // Byte addresses are four times the register index
    localparam logic [11:0] A_OC = {2'b00, `DCL_IDX_OFFSET_MODE, 2'b00};
    localparam logic [11:0] A_LD = {2'b00, `DCL_IDX_LANE_CFG, 2'b00};
    localparam logic [11:0] A_LC = {2'b00, `DCL_IDX_LINK_CTRL, 2'b00};
    always #25 pclk = ~pclk; // Half period of 25 ns
    dcl_regs u_dcl_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_in(sample_in), .sample_out(sample_out),
        .link_word_in(link_word_in), .lane_word(lane_word), .link_on(link_on),
        .scrambler_on(scrambler_on),
        .frames_per_multiframe_less_one(frames_per_multiframe_less_one),
        .driver_swing_sel(driver_swing_sel), .driver_deemph_sel(driver_deemph_sel),
        .link_sync_active(link_sync_active));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One comparison
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask
    // Let k edges pass, then step off the edge
    task automatic settle(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask
    // One APB transfer: setup, then access held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t >= 20) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Reset values and read back of every register
    task automatic t_reset();
        apb(1'b0, A_OC, 8'h00);
        chk("oc reset", 32'h00, rd);
        apb(1'b0, A_LD, 8'h00);
        chk("ld reset", 32'h00, rd);
        apb(1'b0, A_LC, 8'h00);
        chk("lc reset", 32'h7f, rd);
        chk("k reset", 32'h1f, {27'h0, frames_per_multiframe_less_one});
        chk("scr reset", 32'h0, {31'h0, scrambler_on});
        chk("link reset", 32'h1, {31'h0, link_on});
    endtask
    // Every swing and de-emphasis code, reserved bits written as zero
    task automatic t_lane_driver();
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, A_LD, {1'b0, 3'(c), 1'b0, 3'(7 - c)});
            settle(1);
            chk("swing", 32'(c), {29'h0, driver_swing_sel});
            chk("deemph", 32'(7 - c), {29'h0, driver_deemph_sel});
        end
    endtask
    // Link off, reconfigure, link on with data and sync phase
    task automatic t_link();
        @(posedge pclk);
        link_word_in <= 8'ha3;
        apb(1'b1, A_LC, 8'h7e);
        settle(2);
        chk("idle word", 32'h55, {24'h0, lane_word});
        apb(1'b1, A_LC, 8'hc2);
        settle(1);
        chk("scr on", 32'h1, {31'h0, scrambler_on});
        chk("k 17", 32'h10, {27'h0, frames_per_multiframe_less_one});
        chk("still idle", 32'h55, {24'h0, lane_word});
        apb(1'b1, A_LC, 8'hc3);
        settle(1);
        chk("sync high", 32'h1, {31'h0, link_sync_active});
        n = 0;
        while (link_sync_active !== 1'b0 && n < 40) begin
            settle(1);
            n++;
        end
        chk("sync done", 32'h1, {31'h0, n <= 17});
        chk("data word", 32'ha3, {24'h0, lane_word});
        apb(1'b0, A_LC, 8'h00);
        chk("lc back", 32'hc3, rd);
    endtask
    // Bypass, then correction at every time constant: a longer one leaves more offset
    task automatic t_offset();
        sample_in <= 16'sd1000;
        apb(1'b1, A_OC, 8'h00);
        settle(2);
        chk("bypass", 32'd1000, {16'h0, sample_out});
        apb(1'b1, A_OC, 8'h01);
        settle(300);
        ref_out = sample_out;
        chk("corrected", 32'h1, {31'h0, (ref_out < 16'sd1000 && ref_out > 16'sd500)});
        for (int tc = 1; tc < 4; tc++) begin
            apb(1'b1, A_OC, 8'h00);
            apb(1'b1, A_OC, {5'h00, 2'(tc), 1'b1});
            settle(300);
            chk("slower tc", 32'h1, {31'h0, (sample_out > ref_out)});
            ref_out = sample_out;
        end
        apb(1'b0, A_OC, 8'h00);
        chk("oc back", 32'h07, rd);
    endtask
    // Unmapped address: refused write, zero read, error flag
    task automatic t_unmapped();
        apb(1'b1, 12'h004, 8'h5a);
        chk("err wr", 32'h1, {31'h0, err});
        apb(1'b0, 12'h004, 8'h00);
        chk("err rd", 32'h1, {31'h0, err});
        chk("rd zero", 32'h0, rd);
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_lane_driver();
        t_link();
        t_offset();
        t_unmapped();
        tally_and_finish();
    end
endmodule // testbench
